//--- bench/lcd_panel_model.sv
// Passive panel model: integrates pixel voltage and latches dark pixels
module lcd_panel_model
#(
   parameter int SEG = 2
) (
   // Clock and measurement control
   input  wire logic                              sys_clk_i,
   input  wire logic                              clr_i,
   input  wire logic                              meas_i,
   // Panel lines
   input  lcd_pkg::pin_drive_t [3:0]              com_i,
   input  lcd_pkg::pin_drive_t [lcd_pkg::NUM_SEG-1:0] seg_i,
   // Observations for one segment column
   output int                                     dc_o [4],
   output logic [3:0]                             dark_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import lcd_pkg::*;

   int d;

   // Pixel sees common minus segment; full swing while selected is dark
   always @(posedge sys_clk_i) begin
      for (int k = 0; k < 4; k++) begin
         d = int'(com_i[k].level) - int'(seg_i[SEG].level);
         if (clr_i) begin
            dc_o[k] <= 0;
            dark_o[k] <= 1'b0;
         end else if (meas_i && com_i[k].lcd && seg_i[SEG].lcd) begin
            dc_o[k] <= dc_o[k] + d;
            if (com_i[k].level inside {LVL_GND, LVL_FULL}) begin
               dark_o[k] <= dark_o[k] | (d == 3 || d == -3);
            end
         end
      end
   end
endmodule : lcd_panel_model

//--- bench/tb_top.sv
// Testbench: register access, scanning, frame timing and panel checks
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import lcd_pkg::*;

   localparam logic [7:0] CV [3] = '{8'h60, 8'h11, 8'h06};

   logic                     clk = 1'b0;
   logic                     rst = 1'b1;
   logic [7:0]               addr = 8'h00;
   logic [7:0]               wdata = 8'h00;
   logic                     wr = 1'b0;
   logic                     rd = 1'b0;
   logic                     xtal = 1'b0;
   logic                     rco = 1'b0;
   logic                     pdn = 1'b0;
   logic                     clr = 1'b1;
   logic                     meas = 1'b0;
   logic [7:0]               rdata;
   pin_drive_t [3:0]         com;
   pin_drive_t [NUM_SEG-1:0] seg;
   logic                     trim;
   logic                     bias;
   logic [1:0]               ladder;
   logic [NUM_SEG-1:0]       gpio;
   int                       dc [4];
   logic [3:0]               dark;
   int                       failures = 0;
   int                       n_compared = 0;
   int                       n;

   always #5 clk = ~clk;
   initial begin
      #3;
      forever #50 xtal = ~xtal;
   end
   initial begin
      #7;
      forever #30 rco = ~rco;
   end

   lcd_segment_driver lcd_segment_driver_inst (
      .sys_clk_i    (clk),
      .rst_i        (rst),
      .addr_i       (addr),
      .wdata_i      (wdata),
      .wr_i         (wr),
      .rd_i         (rd),
      .rdata_o      (rdata),
      .xtal_clk_i   (xtal),
      .rco_clk_i    (rco),
      .power_down_i (pdn),
      .com_drive_o  (com),
      .seg_drive_o  (seg),
      .drive_trim_o (trim),
      .bias_half_o  (bias),
      .ladder_sel_o (ladder),
      .seg_gpio_o   (gpio)
   );

   lcd_panel_model #(.SEG(2)) lcd_panel_model_inst (
      .sys_clk_i (clk),
      .clr_i     (clr),
      .meas_i    (meas),
      .com_i     (com),
      .seg_i     (seg),
      .dc_o      (dc),
      .dark_o    (dark)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic finish_test();
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : idle

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rdchk

   // Cycles until any panel line changes, capped at lim
   task automatic wait_chg(input int lim, output int cnt);
      logic [107:0] prev;
      prev = {com, seg};
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
      end while ({com, seg} === prev && cnt < lim);
   endtask : wait_chg

   // First interval resynchronises, second one is measured
   task automatic period(input int lim, input int exp);
      idle(1);
      wait_chg(lim, n);
      wait_chg(lim, n);
      check(n, exp);
   endtask : period

   function automatic logic [5:0] lines();
      return {seg[1].lcd, seg[0].lcd,
              com[3].lcd, com[2].lcd, com[1].lcd, com[0].lcd};
   endfunction : lines

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      rdchk(CTRL_ADDR, CTRL_RST);
      rdchk(CLKCTL_ADDR, CLKCTL_RST);
      rdchk(SEG_EN_ADDR[0], BYTE_RST);
      rdchk(DATA_ADDR, BYTE_RST);
      rdchk(8'h00, 8'h00);
      check({trim, bias, ladder, lines()}, 32'h0);
      foreach (CV[i]) begin
         wreg(CTRL_ADDR, CV[i]);
         rdchk(CTRL_ADDR, CV[i] & CTRL_WMASK);
         check({trim, bias, ladder}, {CV[i][6], CV[i][4], CV[i][1:0]});
      end
      for (int i = 0; i < NUM_BYTES; i++) begin
         wreg(PTR_ADDR, 8'(i));
         wreg(DATA_ADDR, 8'hc0 | 8'(i));
      end
      for (int i = 0; i < NUM_BYTES; i++) begin
         wreg(PTR_ADDR, 8'(i));
         rdchk(DATA_ADDR, 8'(i));
      end
      wreg(PTR_ADDR, 8'hff);
      rdchk(PTR_ADDR, 8'h1f);
      wreg(PTR_ADDR, 8'h02);
      wreg(DATA_ADDR, 8'h0d);
      // Crystal and analog pins stay out of the enabled set
      wreg(SEG_EN_ADDR[0], 8'h0c);
      wreg(IO_DATA_ADDR[0], 8'hff);
      rdchk(IO_DATA_ADDR[0], 8'hff);
      wreg(CTRL_ADDR, 8'h80);
      idle(3);
      check(lines(), 6'h0f);
      check({seg[4].lcd, seg[3].lcd, seg[2].lcd}, 3'b011);
      rdchk(IO_DATA_ADDR[0], 8'hf3);
      check(gpio[7:0], 8'hff);
      wait_chg(9000, n);
      clr <= 1'b0;
      meas <= 1'b1;
      wait_chg(9000, n);
      check(n, 4096);
      repeat (7) wait_chg(9000, n);
      meas <= 1'b0;
      idle(2);
      foreach (dc[k]) check(dc[k], 0);
      check(dark, 4'b1101);
      wreg(CLKCTL_ADDR, 8'h01);
      period(20000, 8192);
      wreg(CLKCTL_ADDR, 8'h10);
      period(2000, 160);
      @(posedge clk);
      pdn <= 1'b1;
      period(2000, 160);
      wreg(CLKCTL_ADDR, 8'h20);
      period(2000, 96);
      wreg(CLKCTL_ADDR, 8'h00);
      period(5000, 5000);
      @(posedge clk);
      pdn <= 1'b0;
      wreg(CTRL_ADDR, 8'h00);
      idle(3);
      check(lines(), 6'h00);
      rdchk(IO_DATA_ADDR[0], 8'hff);
      // Half bias on the fast oscillator: balance and contrast
      wreg(CTRL_ADDR, 8'h10);
      wreg(CLKCTL_ADDR, 8'h20);
      wreg(CTRL_ADDR, 8'h90);
      clr <= 1'b1;
      idle(3);
      check(bias, 1'b1);
      wait_chg(2000, n);
      clr <= 1'b0;
      meas <= 1'b1;
      repeat (8) wait_chg(2000, n);
      meas <= 1'b0;
      idle(2);
      foreach (dc[k]) check(dc[k], 0);
      check(dark, 4'b1101);
      wreg(CTRL_ADDR, 8'h10);
      wreg(CTRL_ADDR, 8'h04);
      wreg(CTRL_ADDR, 8'h84);
      idle(3);
      check(lines(), 6'h07);
      wreg(CTRL_ADDR, 8'h04);
      wreg(CTRL_ADDR, 8'h08);
      wreg(CTRL_ADDR, 8'h88);
      idle(3);
      check(lines(), 6'h3f);
      finish_test();
   end

   initial begin
      #1_000_000;
      failures++;
      finish_test();
   end
endmodule : tb_top

//--- common/lcd_pkg.sv
// Constants and types shared by the segment display driver
package lcd_pkg;

   // Register offsets
   localparam logic [7:0] CTRL_ADDR    = 8'hf9;
   localparam logic [7:0] CLKCTL_ADDR  = 8'hfa;
   localparam logic [7:0] PTR_ADDR     = 8'hfb;
   localparam logic [7:0] DATA_ADDR    = 8'hfc;
   localparam logic [7:0] SEG_EN_ADDR [4] = '{8'he5, 8'he6, 8'he7, 8'hee};
   localparam logic [7:0] IO_DATA_ADDR [4] = '{8'hd8, 8'hd9, 8'hda, 8'hdb};

   // Writable bits and reset values
   localparam logic [7:0] CTRL_WMASK   = 8'hdf;
   localparam logic [7:0] CLKCTL_WMASK = 8'h37;
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] CLKCTL_RST   = 8'h00;
   localparam logic [7:0] BYTE_RST     = 8'h00;

   // Sizes
   localparam int NUM_BYTES = 32;
   localparam int NUM_SEG   = 32;
   localparam int NUM_BANKS = 4;
   localparam int DATA_W    = 6;
   localparam int PTR_W     = 5;

   // Frame clock prescale and divider
   localparam logic [11:0] SYS_PRESC_MASK = 12'hfff;
   localparam logic [11:0] LS_PRESC_MASK  = 12'h00f;
   localparam logic [2:0]  DIV_MAX_CODE   = 3'h5;

   typedef enum logic [1:0] {
      DUTY_4    = 2'b00,
      DUTY_3    = 2'b01,
      DUTY_6    = 2'b10,
      DUTY_RSVD = 2'b11
   } duty_t;

   typedef enum logic [1:0] {
      SRC_SYS  = 2'b00,
      SRC_XTAL = 2'b01,
      SRC_RCO  = 2'b10,
      SRC_RSVD = 2'b11
   } src_t;

   // Drive level: ground, low tap, high tap, full panel supply
   typedef enum logic [1:0] {
      LVL_GND  = 2'h0,
      LVL_LOW  = 2'h1,
      LVL_HIGH = 2'h2,
      LVL_FULL = 2'h3
   } lvl_t;

   typedef struct packed {
      logic       en;
      logic       trim;
      logic       rsvd;
      logic       bias_half;
      duty_t      duty;
      logic [1:0] ladder;
   } ctrl_t;

   typedef struct packed {
      logic [1:0] rsvd_hi;
      src_t       src;
      logic       rsvd_lo;
      logic [2:0] div;
   } clkctl_t;

   typedef struct packed {
      logic lcd;
      lvl_t level;
   } pin_drive_t;

endpackage : lcd_pkg

//--- hdl/lcd_segment_driver.sv
// Multiplexed segment display driver with register port
//
// Contract
// RULE1: Enable bit set turns the driver on and drives pins from display bytes.
// RULE2: Enable clear returns every common and segment pin to general I/O.
// RULE3: Duty field 00 is 1/4, 01 is 1/3, 10 is 1/6, 11 reserved.
// RULE4: Bias bit 0 selects 1/3 bias, 1 selects 1/2 bias, type A.
// RULE5: Ladder field picks 150k, 300k or 600k; code 11 reserved.
// RULE6: Control bit 6 trims drive supply to full or ninety percent.
// RULE7: Software keeps duty and bias unchanged while driver is enabled.
// RULE8: Frame clock is source over prescale 2^12 or 2^4, then divider.
// RULE9: Low-speed sources keep scanning through power-down.
// RULE10: Commons scan one at a time; 1/3 duty frees common 3.
// RULE11: At 1/6 duty segment pins 0 and 1 become commons 4 and 5.
// RULE12: Display bit 1 darkens a pixel, 0 clears it.
// RULE13: Thirty-two display bytes reached through pointer and data port.
// RULE14: Each byte feeds one segment pin, one bit per common line.
// RULE15: Stored data reach segments with the frame clock, no software help.
// RULE16: Segment enables act only while enabled; only those pins drive. At 1/6 duty segment pins 0 and 1 drive as commons without enables.
// RULE17: Software clears segment enables on pins used for crystal or analog.
// RULE18: Waveforms keep the average pixel voltage at zero.
// RULE19: Software picks source and divider for 30 Hz to 100 Hz frames.
// RULE20: Divider codes 000 to 101 divide by 1 to 32; rest reserved.
// RULE21: Five-bit pointer selects the byte the data port reaches.
// RULE22: Data port write stores six bits into the pointed byte.
// RULE23: Enabled segment pin reads 0 from its I/O data bit; writes still latch.
// RULE24: Sequencer steps one phase per common and flips polarity per frame.
// RULE25: Everything resets to zero: disabled, 1/4 duty, 1/3 bias, 150k.
//
// The plain strobed port was decided locally.
module lcd_segment_driver (
   // Clock and reset
   input  wire logic                                      sys_clk_i,
   input  wire logic                                      rst_i,
   // Register port
   input  wire logic [7:0]                                addr_i,
   input  wire logic [7:0]                                wdata_i,
   input  wire logic                                      wr_i,
   input  wire logic                                      rd_i,
   output logic      [7:0]                                rdata_o,
   // Clock sources and power state
   input  wire logic                                      xtal_clk_i,
   input  wire logic                                      rco_clk_i,
   input  wire logic                                      power_down_i,
   // Panel drive
   output lcd_pkg::pin_drive_t [3:0]                      com_drive_o,
   output lcd_pkg::pin_drive_t [lcd_pkg::NUM_SEG-1:0]     seg_drive_o,
   // Analog controls
   output logic                                           drive_trim_o,
   output logic                                           bias_half_o,
   output logic      [1:0]                                ladder_sel_o,
   // Shared I/O latch
   output logic      [lcd_pkg::NUM_SEG-1:0]               seg_gpio_o
);
   import lcd_pkg::*;

   // Register state
   ctrl_t                 ctrl_ff,   nxt_ctrl;
   clkctl_t               clkc_ff,   nxt_clkc;
   logic [PTR_W-1:0]      ptr_ff,    nxt_ptr;
   logic [NUM_SEG-1:0]    seg_en_ff, nxt_seg_en;
   logic [NUM_SEG-1:0]    io_ff,     nxt_io;
   logic [7:0]            rdata_ff,  nxt_rdata;
   logic [DATA_W-1:0]     mem_ff [NUM_BYTES];
   logic                  mem_we;

   // Timing state
   logic [2:0]            xtal_sync_ff;
   logic [2:0]            rco_sync_ff;
   logic [11:0]           presc_ff,  nxt_presc;
   logic [4:0]            div_ff,    nxt_div;
   logic [2:0]            phase_ff,  nxt_phase;
   logic                  pol_ff,    nxt_pol;
   logic                  presc_step;
   logic                  presc_tick;
   logic                  frame_tick;
   logic [11:0]           presc_mask;
   logic [4:0]            div_mask;
   logic [2:0]            last_phase;

   // Drive state
   pin_drive_t [3:0]         com_ff,  nxt_com;
   pin_drive_t [NUM_SEG-1:0] seg_ff,  nxt_seg;

   function automatic lvl_t com_level(input logic sel, input logic pol);
      if (sel) begin
         com_level = pol ? LVL_GND : LVL_FULL;
      end else begin
         com_level = pol ? LVL_HIGH : LVL_LOW;
      end
   endfunction : com_level

   // Off pixels sit one third away at 1/3 bias, zero away at 1/2 bias
   function automatic lvl_t seg_level(input logic on, input logic pol,
                                      input logic half);
      if (on) begin
         seg_level = pol ? LVL_FULL : LVL_GND;
      end else if (half) begin
         seg_level = pol ? LVL_GND : LVL_FULL;
      end else begin
         seg_level = pol ? LVL_LOW : LVL_HIGH;
      end
   endfunction : seg_level

   // Register writes and reads
   always_comb begin
      nxt_ctrl   = ctrl_ff;
      nxt_clkc   = clkc_ff;
      nxt_ptr    = ptr_ff;
      nxt_seg_en = seg_en_ff;
      nxt_io     = io_ff;
      nxt_rdata  = 8'h00;
      mem_we     = 1'b0;
      if (wr_i) begin
         case (addr_i)
            CTRL_ADDR:   nxt_ctrl = ctrl_t'(wdata_i & CTRL_WMASK); // RULE1
            CLKCTL_ADDR: nxt_clkc = clkctl_t'(wdata_i & CLKCTL_WMASK);
            PTR_ADDR:    nxt_ptr  = wdata_i[PTR_W-1:0]; // RULE21
            DATA_ADDR:   mem_we   = 1'b1; // RULE22
            default:     nxt_ptr  = ptr_ff;
         endcase
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (addr_i == SEG_EN_ADDR[b]) begin
               nxt_seg_en[8*b +: 8] = wdata_i;
            end
            if (addr_i == IO_DATA_ADDR[b]) begin
               nxt_io[8*b +: 8] = wdata_i; // RULE23
            end
         end
      end
      if (rd_i) begin
         case (addr_i)
            CTRL_ADDR:   nxt_rdata = ctrl_ff;
            CLKCTL_ADDR: nxt_rdata = clkc_ff;
            PTR_ADDR:    nxt_rdata = {3'h0, ptr_ff};
            DATA_ADDR:   nxt_rdata = {2'h0, mem_ff[ptr_ff]}; // RULE13
            default:     nxt_rdata = 8'h00;
         endcase
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (addr_i == SEG_EN_ADDR[b]) begin
               nxt_rdata = seg_en_ff[8*b +: 8];
            end
            if (addr_i == IO_DATA_ADDR[b]) begin
               nxt_rdata = io_ff[8*b +: 8]
                           & ~(seg_en_ff[8*b +: 8] & {8{ctrl_ff.en}}); // RULE23
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_ff   <= ctrl_t'(CTRL_RST); // RULE25
         clkc_ff   <= clkctl_t'(CLKCTL_RST);
         ptr_ff    <= '0;
         seg_en_ff <= '0;
         io_ff     <= '0;
         rdata_ff  <= 8'h00;
         for (int i = 0; i < NUM_BYTES; i++) begin
            mem_ff[i] <= BYTE_RST[DATA_W-1:0];
         end
      end else begin
         ctrl_ff   <= nxt_ctrl;
         clkc_ff   <= nxt_clkc;
         ptr_ff    <= nxt_ptr;
         seg_en_ff <= nxt_seg_en;
         io_ff     <= nxt_io;
         rdata_ff  <= nxt_rdata;
         if (mem_we) begin
            mem_ff[ptr_ff] <= wdata_i[DATA_W-1:0]; // RULE22
         end
      end
   end

   // Frame clock: source step, prescale, divider
   always_comb begin
      unique case (clkc_ff.src)
         SRC_SYS:  presc_step = !power_down_i; // RULE9
         SRC_XTAL: presc_step = xtal_sync_ff[1] & ~xtal_sync_ff[2];
         SRC_RCO:  presc_step = rco_sync_ff[1] & ~rco_sync_ff[2];
         SRC_RSVD: presc_step = 1'b0;
      endcase
      presc_mask = (clkc_ff.src == SRC_SYS) ? SYS_PRESC_MASK
                                             : LS_PRESC_MASK; // RULE8
      presc_tick = presc_step && (presc_ff >= presc_mask);
      div_mask   = 5'((6'h01 << clkc_ff.div) - 6'h01); // RULE20
      frame_tick = presc_tick && (clkc_ff.div <= DIV_MAX_CODE)
                   && (div_ff >= div_mask); // RULE8
      nxt_presc  = presc_ff;
      nxt_div    = div_ff;
      if (!ctrl_ff.en) begin
         nxt_presc = '0;
         nxt_div   = '0;
      end else if (presc_step) begin
         nxt_presc = presc_tick ? 12'h000 : presc_ff + 12'h001;
         if (presc_tick) begin
            nxt_div = frame_tick ? 5'h00 : div_ff + 5'h01;
         end
      end
   end

   // Common sequencer
   always_comb begin
      unique case (ctrl_ff.duty)
         DUTY_3:  last_phase = 3'h2; // RULE10
         DUTY_6:  last_phase = 3'h5; // RULE3
         default: last_phase = 3'h3;
      endcase
      nxt_phase = phase_ff;
      nxt_pol   = pol_ff;
      if (!ctrl_ff.en) begin
         nxt_phase = 3'h0;
         nxt_pol   = 1'b0;
      end else if (frame_tick) begin
         if (phase_ff >= last_phase) begin
            nxt_phase = 3'h0;
            nxt_pol   = ~pol_ff; // RULE24
         end else begin
            nxt_phase = phase_ff + 3'h1; // RULE24
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         xtal_sync_ff <= 3'h0;
         rco_sync_ff  <= 3'h0;
         presc_ff     <= 12'h000;
         div_ff       <= 5'h00;
         phase_ff     <= 3'h0;
         pol_ff       <= 1'b0;
      end else begin
         xtal_sync_ff <= {xtal_sync_ff[1:0], xtal_clk_i};
         rco_sync_ff  <= {rco_sync_ff[1:0], rco_clk_i};
         presc_ff     <= nxt_presc;
         div_ff       <= nxt_div;
         phase_ff     <= nxt_phase;
         pol_ff       <= nxt_pol;
      end
   end

   // Common pin drive
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         nxt_com[c].lcd = ctrl_ff.en
                          && !(ctrl_ff.duty == DUTY_3 && c == 3); // RULE10
         nxt_com[c].level = nxt_com[c].lcd
                            ? com_level(phase_ff == 3'(c), pol_ff)
                            : LVL_GND; // RULE18
      end
   end

   // Segment pin drive, one byte per pin
   for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
      logic on_bit;
      logic as_com;
      assign on_bit = mem_ff[s][phase_ff]; // RULE14 RULE12
      if (s < 2) begin : g_shared
         assign as_com = (ctrl_ff.duty == DUTY_6); // RULE11
      end else begin : g_plain
         assign as_com = 1'b0;
      end
      always_comb begin
         if (!ctrl_ff.en) begin
            nxt_seg[s] = '{lcd: 1'b0, level: LVL_GND}; // RULE2
         end else if (as_com) begin
            nxt_seg[s] = '{lcd: 1'b1,
                           level: com_level(phase_ff == 3'(s + 4),
                                            pol_ff)}; // RULE11
         end else if (seg_en_ff[s]) begin
            nxt_seg[s] = '{lcd: 1'b1,
                           level: seg_level(on_bit, pol_ff,
                                            ctrl_ff.bias_half)}; // RULE15
         end else begin
            nxt_seg[s] = '{lcd: 1'b0, level: LVL_GND}; // RULE16
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         com_ff <= '0;
         seg_ff <= '0;
      end else begin
         com_ff <= nxt_com; // RULE1
         seg_ff <= nxt_seg;
      end
   end

   assign com_drive_o  = com_ff;
   assign seg_drive_o  = seg_ff;
   assign rdata_o      = rdata_ff;
   assign seg_gpio_o   = io_ff;
   assign drive_trim_o = ctrl_ff.trim; // RULE6
   assign bias_half_o  = ctrl_ff.bias_half; // RULE4
   assign ladder_sel_o = ctrl_ff.ladder; // RULE5

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   off_reverts_a: assert property ( // RULE2
      !ctrl_ff.en |=> (com_drive_o[0].lcd == 1'b0)
                      && (seg_drive_o == '0))
      else $error("pins still driven while disabled");

   ctrl_read_a: assert property ( // RULE1
      (rd_i && addr_i == CTRL_ADDR) |=> rdata_o == $past(ctrl_ff))
      else $error("control read data wrong");

   phase_range_a: assert property ( // RULE10
      ctrl_ff.en |-> phase_ff <= last_phase)
      else $error("common phase beyond duty");

   frame_flip_a: assert property ( // RULE24
      (frame_tick && phase_ff == last_phase && ctrl_ff.en)
      |=> pol_ff != $past(pol_ff) && phase_ff == 3'h0)
      else $error("polarity not flipped at frame end");

   shared_com_a: assert property ( // RULE11
      (ctrl_ff.en && ctrl_ff.duty == DUTY_6)
      |=> seg_drive_o[0].lcd && seg_drive_o[1].lcd)
      else $error("shared pins not acting as commons");

   port_store_a: assert property ( // RULE22
      (wr_i && addr_i == DATA_ADDR)
      |=> mem_ff[$past(ptr_ff)] == $past(wdata_i[DATA_W-1:0]))
      else $error("display byte not stored");

   io_mask_a: assert property ( // RULE23
      (rd_i && addr_i == IO_DATA_ADDR[0] && ctrl_ff.en && seg_en_ff[2])
      |=> rdata_o[2] == 1'b0)
      else $error("enabled segment reads nonzero");

   sys_prescale_a: assert property ( // RULE8
      (frame_tick && clkc_ff.src == SRC_SYS) |-> presc_ff == SYS_PRESC_MASK)
      else $error("system prescale wrong");

   pd_hold_a: assert property ( // RULE9
      (power_down_i && clkc_ff.src == SRC_SYS) |-> !frame_tick)
      else $error("system source ran in power-down");

   reset_zero_a: assert property ( // RULE25
      $past(rst_i) |-> ctrl_ff == '0 && seg_en_ff == '0)
      else $error("control not zero after reset");

endmodule : lcd_segment_driver
